//--- verilog/cell_ram_pkg.sv
`default_nettype none
package cell_ram_pkg;
	localparam int          ADDR_W       = 4;
	localparam int          DEPTH        = 16;
	localparam logic        MEM_RST_VAL  = 1'h0;
	localparam logic        WCLK_RST_VAL = 1'h0;
	localparam int          WCLK_PULSE_MAX_MS = 1;

	typedef enum logic [1:0] {
		MODE_LEVEL,
		MODE_EDGE,
		MODE_DUAL
	} mem_mode_e;

	typedef enum logic [1:0] {
		ORG_16X2,
		ORG_32X1,
		ORG_16X1
	} mem_org_e;
endpackage
`default_nettype wire

//--- verilog/lut_if.sv
`default_nettype none
interface lut_if #(parameter int AW = 4);
	logic          we;
	logic [AW-1:0] waddr;
	logic          wdata;
	logic [AW-1:0] raddr;
	logic          rdata;

	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- verilog/lut_store.sv
`default_nettype none
module lut_store #(
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_srst,
	// Table access
	lut_if.mem        bus
);
	import cell_ram_pkg::*;

	logic [DEPTH-1:0] mem_ff;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			mem_ff <= {DEPTH{MEM_RST_VAL}};
		end else if (bus.we) begin
			mem_ff[bus.waddr] <= bus.wdata;
		end
	end

	// Read is combinational from the stored bits
	assign bus.rdata = mem_ff[bus.raddr];
endmodule
`default_nettype wire

//--- verilog/logic_cell_distributed_ram.sv
// Functional notes
// - The two tables act as a 16x2, 32x1 or 16x1 memory depending on the organisation selected.
// - Dual-port mode joins both tables into one 16x1 array with one write port and two read ports.
// - The dual-port array accepts a read and a write in the same cycle at any two addresses or the same one.
// - Dual-port writes happen only on a write clock edge, never on the strobe level.
// - The primary address reads and writes the first table and the single-port output shows that bit, except in the 32x1 upper half where both use the second table.
// - In dual mode the second read address reads the second table onto the second output while its write address stays primary.
// - In dual mode and 16x1 a write edge with the strobe high stores the data bit at the primary address in both tables alike.
// - In level mode a high strobe writes transparently, so data changes during it overwrite the location.
// - In level mode an address change under a high strobe writes the new location at the next clock edge and no other location.
// - The second data input is data for the second table in 16x2 only and the fifth address bit in 32x1; 16x1 writes the first data bit to both tables.
`default_nettype none
module logic_cell_distributed_ram (
	// Clock and reset
	input  wire logic                           i_clk_sys,
	input  wire logic                           i_srst,
	// Configuration
	input  wire cell_ram_pkg::mem_mode_e        i_mode,
	input  wire cell_ram_pkg::mem_org_e         i_org,
	// Write side
	input  wire logic                           i_write_clock,
	input  wire logic                           i_write_strobe,
	input  wire logic                           i_first_data_control_input,
	input  wire logic                           i_second_data_control_input,
	input  wire logic [cell_ram_pkg::ADDR_W-1:0] i_address,
	// Second read port
	input  wire logic [cell_ram_pkg::ADDR_W-1:0] i_second_read_address,
	// Read outputs
	output logic                                o_single_port_read_out,
	output logic                                o_second_port_read_out
);
	import cell_ram_pkg::*;

	logic     wclk_ff;
	logic     wclk_rise;
	logic     wr;
	logic     dual;
	logic     hi_half;
	mem_org_e org_eff;

	lut_if #(.AW(ADDR_W)) f_bus ();
	lut_if #(.AW(ADDR_W)) g_bus ();

	// Write clock is sampled; its rising edge is the active edge
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			wclk_ff <= WCLK_RST_VAL;
		end else begin
			wclk_ff <= i_write_clock;
		end
	end

	always_comb begin
		wclk_rise = i_write_clock & ~wclk_ff;
		dual      = (i_mode == MODE_DUAL);
		org_eff   = dual ? ORG_16X1 : i_org;
		hi_half   = (org_eff == ORG_32X1) & i_second_data_control_input;
		if (i_mode == MODE_LEVEL) begin
			wr = i_write_strobe;
		end else begin
			wr = i_write_strobe & wclk_rise;
		end
		// Both tables share the primary write address
		f_bus.waddr = i_address;
		g_bus.waddr = i_address;
		f_bus.wdata = i_first_data_control_input;
		g_bus.wdata = (org_eff == ORG_16X2) ? i_second_data_control_input : i_first_data_control_input;
		f_bus.we    = wr & ~hi_half;
		g_bus.we    = wr & ((org_eff != ORG_32X1) | hi_half);
		f_bus.raddr = i_address;
		g_bus.raddr = dual ? i_second_read_address : i_address;
		// Outputs are plain muxes of the stored bits
		o_single_port_read_out = hi_half ? g_bus.rdata : f_bus.rdata;
		o_second_port_read_out = g_bus.rdata;
	end

	lut_store #(.DEPTH(DEPTH)) u_table_f (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.bus       (f_bus)
	);

	lut_store #(.DEPTH(DEPTH)) u_table_g (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.bus       (g_bus)
	);

	a_dual_copies_match: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_DUAL && wclk_rise && i_write_strobe)
		##1 (i_mode == MODE_DUAL && i_second_read_address == $past(i_address) && i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)
			&& o_second_port_read_out == $past(i_first_data_control_input)))
		else $error("dual write did not reach both tables");

	// Copies only agree for words written in dual mode or in 16x1, so look right after a dual write
	a_dual_same_addr: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_DUAL && wclk_rise && i_write_strobe)
		##1 (i_mode == MODE_DUAL && i_address == $past(i_address) && i_address == i_second_read_address)
		|-> (o_single_port_read_out == o_second_port_read_out))
		else $error("dual tables disagree at one address");

	a_dual_no_level: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_DUAL && i_write_strobe && !wclk_rise)
		##1 (i_mode == MODE_DUAL && $stable(i_address))
		|-> $stable(o_single_port_read_out))
		else $error("dual mode wrote without a write clock edge");

	a_edge_no_write: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_EDGE && i_org == ORG_16X1 && !wclk_rise)
		##1 (i_mode == MODE_EDGE && i_org == ORG_16X1 && $stable(i_address))
		|-> $stable(o_single_port_read_out))
		else $error("edge mode changed data without an edge");

	a_level_transparent: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_LEVEL && i_org == ORG_16X1 && i_write_strobe)
		##1 (i_mode == MODE_LEVEL && i_org == ORG_16X1 && i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)))
		else $error("level write not transparent");

	a_level_addr_move: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_LEVEL && i_org == ORG_16X1 && i_write_strobe && $changed(i_address))
		##1 (i_mode == MODE_LEVEL && i_org == ORG_16X1 && i_address == $past(i_address))
		|-> (o_second_port_read_out == $past(i_first_data_control_input)))
		else $error("new address not written under strobe");

	a_org_two_bits: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_EDGE && i_org == ORG_16X2 && wclk_rise && i_write_strobe)
		##1 (i_mode == MODE_EDGE && i_org == ORG_16X2 && i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)
			&& o_second_port_read_out == $past(i_second_data_control_input)))
		else $error("16x2 word not stored");

	a_org_upper_half: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_EDGE && i_org == ORG_32X1 && wclk_rise && i_write_strobe && i_second_data_control_input)
		##1 (i_mode == MODE_EDGE && i_org == ORG_32X1 && i_second_data_control_input
			&& i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)))
		else $error("32x1 upper half not stored");

	a_org_lower_half: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_EDGE && i_org == ORG_32X1 && wclk_rise && i_write_strobe
			&& !i_second_data_control_input)
		##1 (i_mode == MODE_EDGE && i_org == ORG_32X1 && !i_second_data_control_input
			&& i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)))
		else $error("32x1 lower half not stored");

	a_level_upper_half: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_LEVEL && i_org == ORG_32X1 && i_write_strobe && i_second_data_control_input)
		##1 (i_mode == MODE_LEVEL && i_org == ORG_32X1 && i_second_data_control_input
			&& i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)))
		else $error("level 32x1 upper half not stored");

	a_level_two_bits: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_LEVEL && i_org == ORG_16X2 && i_write_strobe)
		##1 (i_mode == MODE_LEVEL && i_org == ORG_16X2 && i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)
			&& o_second_port_read_out == $past(i_second_data_control_input)))
		else $error("level 16x2 word not stored");

	a_edge_single_word: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_EDGE && i_org == ORG_16X1 && wclk_rise && i_write_strobe)
		##1 (i_mode == MODE_EDGE && i_org == ORG_16X1 && i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)
			&& o_second_port_read_out == $past(i_first_data_control_input)))
		else $error("16x1 edge write not stored");

	// Organisation input must not matter once the cell is in dual mode
	a_dual_org_ignored: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_DUAL && wclk_rise && i_write_strobe)
		##1 (i_mode == MODE_DUAL && i_address == $past(i_address))
		|-> (o_single_port_read_out == $past(i_first_data_control_input)))
		else $error("dual write depended on organisation");

	a_dual_second_port: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode == MODE_DUAL && wclk_rise && i_write_strobe)
		##1 (i_mode == MODE_DUAL && i_second_read_address == $past(i_address))
		|-> (o_second_port_read_out == $past(i_first_data_control_input)))
		else $error("second port missed the written word");

	// Without a strobe in the clocked modes nothing stored may move
	a_idle_no_change: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(i_mode != MODE_LEVEL && !i_write_strobe)
		##1 (i_mode == $past(i_mode) && i_org == $past(i_org) && $stable(i_address)
			&& $stable(i_second_read_address) && $stable(i_second_data_control_input))
		|-> ($stable(o_single_port_read_out)
			&& $stable(o_second_port_read_out)))
		else $error("stored bit moved without a strobe");

	// Reset clears every cell, so both reads show zero one edge later
	a_reset_clears_cells: assert property (
		@(posedge i_clk_sys)
		i_srst
		|=> (!o_single_port_read_out && !o_second_port_read_out))
		else $error("cells not cleared by reset");
endmodule
`default_nettype wire

//--- bench/wclk_driver.sv
`default_nettype none
module wclk_driver (
	// Clock and frame control
	input  wire logic i_clk_sys,
	input  wire logic i_run,
	// Write clock to the cell
	output logic      o_write_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_write_clock = 1'h0;
	// One cycle high per frame, then it stands at 0 until the next frame
	always @(negedge i_clk_sys) begin
		o_write_clock <= i_run & ~o_write_clock;
	end
endmodule
`default_nettype wire

//--- bench/tb_logic_cell_distributed_ram.sv
`default_nettype none
module tb_logic_cell_distributed_ram;
	import cell_ram_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'h0, srst = 1'h1, run = 1'h0, stb = 1'h0, d0 = 1'h0, d1 = 1'h0;
	logic        wclk, so, second_port_read_out;
	logic [3:0]  a = 4'h0, ra = 4'h0;
	logic [31:0] pick;
	logic        f[16] = '{default: 1'h0};
	logic        g[16] = '{default: 1'h0};
	mem_mode_e   mode = MODE_DUAL;
	mem_org_e    org = ORG_16X2;
	int          bad_count = 0, cmp_count = 0, seed = 32'hC92D36C0;

	always #25 clk = ~clk;

	wclk_driver peer (.i_clk_sys(clk), .i_run(run), .o_write_clock(wclk));

	logic_cell_distributed_ram DUT (.i_clk_sys(clk), .i_srst(srst), .i_mode(mode), .i_org(org),
		.i_write_clock(wclk), .i_write_strobe(stb), .i_first_data_control_input(d0),
		.i_second_data_control_input(d1), .i_address(a), .i_second_read_address(ra),
		.o_single_port_read_out(so), .o_second_port_read_out(second_port_read_out));

	task automatic check(input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: read out %b, expected %b", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("Compares %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic logic exp_so();
		if (mode != MODE_DUAL && org == ORG_32X1 && d1)
			return g[a];
		return f[a];
	endfunction

	function automatic logic exp_do();
		return g[(mode == MODE_DUAL) ? ra : a];
	endfunction

	// Reference store: dual copies D into both tables, 16x2 splits, 32x1 picks a half
	function automatic void model_write();
		logic hi;
		hi = mode != MODE_DUAL && org == ORG_32X1 && d1;
		if (!hi)
			f[a] = d0;
		if (mode == MODE_DUAL || org != ORG_32X1 || hi)
			g[a] = (mode != MODE_DUAL && org == ORG_16X2) ? d1 : d0;
	endfunction

	// One frame: strobe high for two cycles, write clock rises once if nrun
	task automatic op(input mem_mode_e nmode, input mem_org_e norg, input logic [3:0] na,
		input logic [3:0] nra, input logic nd0, input logic nd1, input logic nrun);
		@(negedge clk);
		mode <= nmode;
		org <= norg;
		a <= na;
		ra <= nra;
		d0 <= nd0;
		d1 <= nd1;
		run <= nrun;
		stb <= 1'h1;
		@(negedge clk);
		@(negedge clk);
		if (nrun || mode == MODE_LEVEL)
			model_write();
		check(so, exp_so());
		check(second_port_read_out, exp_do());
		run <= 1'h0;
		stb <= 1'h0;
		ra <= ~nra;
		#1;
		check(second_port_read_out, exp_do());
	endtask

	initial begin
		repeat (6) @(negedge clk);
		srst <= 1'h0;
		#1;
		check(so, 1'h0);
		check(second_port_read_out, 1'h0);
		op(MODE_DUAL, ORG_16X2, 4'h0, 4'h0, 1'h1, 1'h0, 1'h1);
		op(MODE_DUAL, ORG_16X2, 4'hF, 4'h0, 1'h1, 1'h0, 1'h1);
		op(MODE_DUAL, ORG_16X2, 4'hF, 4'hF, 1'h0, 1'h1, 1'h0);
		op(MODE_EDGE, ORG_16X1, 4'h5, 4'h5, 1'h1, 1'h1, 1'h1);
		op(MODE_LEVEL, ORG_16X1, 4'h5, 4'hA, 1'h0, 1'h1, 1'h0);
		for (int i = 0; i < 300; i++) begin
			pick = $random(seed);
			op((pick[1:0] == 2'h0) ? MODE_LEVEL : (pick[1] ? MODE_DUAL : MODE_EDGE),
				pick[2] ? ORG_32X1 : (pick[15] ? ORG_16X1 : ORG_16X2),
				pick[7:4], pick[3] ? pick[7:4] : pick[11:8], pick[12], pick[13], pick[14]);
		end
		tally_and_finish();
	end

	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
